//--- tcl_consts.svh
// constants for the transceiver configuration latch banks
`ifndef TCL_CONSTS_SVH
`define TCL_CONSTS_SVH

// ----------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------
`define TCL_ADDR_W          4
`define TCL_DATA_W          8
`define TCL_NUM_BANKS       16
`define TCL_NUM_CHAN        4
`define TCL_BANKS_PER_CHAN  3
`define TCL_NUM_FORCED      3

// ----------------------------------------------------------------------
// bank offsets
// ----------------------------------------------------------------------
`define TCL_BANK_CHAN_A_RX  4'h0
`define TCL_BANK_CHAN_A_TX  4'h1
`define TCL_BANK_CHAN_A_DYN 4'h2
`define TCL_BANK_CHAN_B_RX  4'h3
`define TCL_BANK_CHAN_B_TX  4'h4
`define TCL_BANK_CHAN_B_DYN 4'h5
`define TCL_BANK_CHAN_C_RX  4'h6
`define TCL_BANK_CHAN_C_TX  4'h7
`define TCL_BANK_CHAN_C_DYN 4'h8
`define TCL_BANK_CHAN_D_RX  4'h9
`define TCL_BANK_CHAN_D_TX  4'ha
`define TCL_BANK_CHAN_D_DYN 4'hb
`define TCL_BANK_GLOBAL_RX  4'hc
`define TCL_BANK_GLOBAL_TX  4'hd
`define TCL_BANK_GLOBAL_DYN 4'he
`define TCL_BANK_MASK       4'hf

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define TCL_GACCEPT_BIT     7
`define TCL_RST_BANK        8'h00
`define TCL_RST_DYN         8'h80
`define TCL_RST_MASK        8'hff
`define TCL_MASK_ALL        8'hff

`endif

//--- tcl_pkg.sv
// types shared by the configuration latch bank files
`include "tcl_consts.svh"

package tcl_pkg;

  // ----------------------------------------------------------------------
  // data types
  // ----------------------------------------------------------------------
  typedef logic [`TCL_ADDR_W-1:0] tcl_addr_t;
  typedef logic [`TCL_DATA_W-1:0] tcl_byte_t;
  typedef logic [`TCL_NUM_BANKS-1:0][`TCL_DATA_W-1:0] tcl_bank_arr_t;

  // role of a bank inside its channel group, one-hot
  typedef enum logic [2:0] {
    TCL_KIND_RX  = 3'b001,
    TCL_KIND_TX  = 3'b010,
    TCL_KIND_DYN = 3'b100
  } tcl_kind_e;

endpackage

//--- tcl_bank.sv
// one eight-latch configuration bank with masked write
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_bank #(
  parameter logic [7:0] RST_VAL = `TCL_RST_BANK
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // write side
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] wr_mask,
  // contents
  output logic      [7:0] bank_q
);

  logic [7:0] bank_ff;

  // bits with a zero mask keep their old value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bank_ff <= RST_VAL;
    end else if (wr_en) begin
      bank_ff <= (bank_ff & ~wr_mask) | (wr_data & wr_mask);
    end
  end

  assign bank_q = bank_ff;

endmodule // tcl_bank

//--- tcl_top.sv
// configuration latch array of a four-channel serial transceiver
`timescale 1ns/100ps
`include "tcl_consts.svh"

module tcl_top (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // configuration pins, asynchronous to mclk
  input  wire logic [3:0] cfg_addr,
  input  wire logic [7:0] cfg_data,
  input  wire logic       config_write_strobe,
  input  wire logic [2:0] forced_global_accept,
  // channel A banks
  output logic      [7:0] chan_a_rx_static,
  output logic      [7:0] chan_a_tx_static,
  output logic      [7:0] chan_a_dynamic,
  // channel B banks
  output logic      [7:0] chan_b_rx_static,
  output logic      [7:0] chan_b_tx_static,
  output logic      [7:0] chan_b_dynamic,
  // channel C banks
  output logic      [7:0] chan_c_rx_static,
  output logic      [7:0] chan_c_tx_static,
  output logic      [7:0] chan_c_dynamic,
  // channel D banks
  output logic      [7:0] chan_d_rx_static,
  output logic      [7:0] chan_d_tx_static,
  output logic      [7:0] chan_d_dynamic,
  // global banks and mask
  output logic      [7:0] global_rx_static,
  output logic      [7:0] global_tx_static,
  output logic      [7:0] global_dynamic,
  output logic      [7:0] write_mask_vector,
  // per-channel accept bits, one per channel
  output logic      [3:0] channel_global_accept
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------

  // channel group that a per-channel bank belongs to
  function automatic logic [1:0] bank_chan(input int unsigned idx);
    bank_chan = 2'(idx / `TCL_BANKS_PER_CHAN);
  endfunction

  // role of a per-channel bank within its group
  function automatic tcl_pkg::tcl_kind_e bank_kind(input int unsigned idx);
    case (idx % `TCL_BANKS_PER_CHAN)
      0:       bank_kind = tcl_pkg::TCL_KIND_RX;
      1:       bank_kind = tcl_pkg::TCL_KIND_TX;
      2:       bank_kind = tcl_pkg::TCL_KIND_DYN;
      default: bank_kind = tcl_pkg::TCL_KIND_RX;
    endcase
  endfunction

  // global bank that broadcasts into a bank of the given role
  function automatic tcl_pkg::tcl_addr_t global_of(input tcl_pkg::tcl_kind_e kind);
    case (kind)
      tcl_pkg::TCL_KIND_RX:  global_of = `TCL_BANK_GLOBAL_RX;
      tcl_pkg::TCL_KIND_TX:  global_of = `TCL_BANK_GLOBAL_TX;
      tcl_pkg::TCL_KIND_DYN: global_of = `TCL_BANK_GLOBAL_DYN;
      default:               global_of = `TCL_BANK_GLOBAL_RX;
    endcase
  endfunction

  // index of the forced enable that goes with a bank role
  function automatic logic [1:0] forced_of(input tcl_pkg::tcl_kind_e kind);
    case (kind)
      tcl_pkg::TCL_KIND_RX:  forced_of = 2'd0;
      tcl_pkg::TCL_KIND_TX:  forced_of = 2'd1;
      tcl_pkg::TCL_KIND_DYN: forced_of = 2'd2;
      default:               forced_of = 2'd0;
    endcase
  endfunction

  // reset value of a bank, chosen by its place in the map
  function automatic logic [7:0] bank_rst(input int unsigned idx);
    if (idx == 32'(`TCL_BANK_MASK)) begin
      bank_rst = `TCL_RST_MASK;
    end else if (idx < 32'(`TCL_BANK_GLOBAL_RX) &&
                 bank_kind(idx) == tcl_pkg::TCL_KIND_DYN) begin
      bank_rst = `TCL_RST_DYN;
    end else begin
      bank_rst = `TCL_RST_BANK;
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // three stages per pin; a value is taken only once stages two and three
  // agree, which also swallows a strobe glitch shorter than two cycles

  logic [3:0] addr_s1_ff;
  logic [3:0] addr_s2_ff;
  logic [3:0] addr_s3_ff;
  logic [3:0] addr_ff;
  logic [7:0] data_s1_ff;
  logic [7:0] data_s2_ff;
  logic [7:0] data_s3_ff;
  logic [7:0] data_ff;
  logic       strb_s1_ff;
  logic       strb_s2_ff;
  logic       strb_s3_ff;
  logic       strb_ff;
  logic [2:0] frc_s1_ff;
  logic [2:0] frc_s2_ff;
  logic [2:0] frc_s3_ff;
  logic [2:0] frc_ff;

  // address stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_s1_ff <= 4'h0;
      addr_s2_ff <= 4'h0;
      addr_s3_ff <= 4'h0;
    end else begin
      addr_s1_ff <= cfg_addr;
      addr_s2_ff <= addr_s1_ff;
      addr_s3_ff <= addr_s2_ff;
    end
  end

  // data stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_s1_ff <= 8'h00;
      data_s2_ff <= 8'h00;
      data_s3_ff <= 8'h00;
    end else begin
      data_s1_ff <= cfg_data;
      data_s2_ff <= data_s1_ff;
      data_s3_ff <= data_s2_ff;
    end
  end

  // strobe stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      strb_s1_ff <= 1'b0;
      strb_s2_ff <= 1'b0;
      strb_s3_ff <= 1'b0;
    end else begin
      strb_s1_ff <= config_write_strobe;
      strb_s2_ff <= strb_s1_ff;
      strb_s3_ff <= strb_s2_ff;
    end
  end

  // forced enable stages
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frc_s1_ff <= 3'h0;
      frc_s2_ff <= 3'h0;
      frc_s3_ff <= 3'h0;
    end else begin
      frc_s1_ff <= forced_global_accept;
      frc_s2_ff <= frc_s1_ff;
      frc_s3_ff <= frc_s2_ff;
    end
  end

  // agreement filters; a bus whose bits still differ keeps its old value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= 4'h0;
      data_ff <= 8'h00;
      strb_ff <= 1'b0;
      frc_ff  <= 3'h0;
    end else begin
      if (addr_s2_ff == addr_s3_ff) begin
        addr_ff <= addr_s3_ff;
      end
      if (data_s2_ff == data_s3_ff) begin
        data_ff <= data_s3_ff;
      end
      if (strb_s2_ff == strb_s3_ff) begin
        strb_ff <= strb_s3_ff;
      end
      if (frc_s2_ff == frc_s3_ff) begin
        frc_ff <= frc_s3_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------------

  tcl_pkg::tcl_bank_arr_t bank_q;
  logic [15:0]            bank_we;
  logic [3:0]             gaccept;

  // accept bit of each channel lives in its dynamic bank
  always_comb begin
    for (int c = 0; c < `TCL_NUM_CHAN; c++) begin
      gaccept[c] = bank_q[c * `TCL_BANKS_PER_CHAN + 2][`TCL_GACCEPT_BIT];
    end
  end

  // direct hit on the addressed bank, plus broadcast from a global bank;
  // the level strobe rewrites every cycle it is high, which is harmless
  // because a masked write of the same byte is idempotent
  always_comb begin
    tcl_pkg::tcl_kind_e kind;
    logic [1:0]         chan;
    kind = tcl_pkg::TCL_KIND_RX;
    chan = 2'd0;
    for (int unsigned b = 0; b < `TCL_NUM_BANKS; b++) begin
      bank_we[b] = strb_ff && (addr_ff == 4'(b));
    end
    for (int unsigned b = 0; b < 32'(`TCL_BANK_GLOBAL_RX); b++) begin
      kind = bank_kind(b);
      chan = bank_chan(b);
      if (strb_ff && addr_ff == global_of(kind) &&
          (gaccept[chan] || frc_ff[forced_of(kind)])) begin
        bank_we[b] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // latch banks
  // ----------------------------------------------------------------------

  // global and channel banks obey the mask; the mask bank ignores it
  for (genvar g = 0; g < `TCL_NUM_BANKS; g++) begin : g_bank
    localparam logic [7:0] RST_V = bank_rst(g);
    logic [7:0] msk;
    assign msk = (g == `TCL_BANK_MASK) ? `TCL_MASK_ALL
                                       : bank_q[`TCL_BANK_MASK];
    tcl_bank #(
      .RST_VAL (RST_V)
    ) u_bank (
      .mclk    (mclk),
      .nrst    (nrst),
      .wr_en   (bank_we[g]),
      .wr_data (data_ff),
      .wr_mask (msk),
      .bank_q  (bank_q[g])
    );
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------

  // every output is a bank flip-flop seen through a wire
  assign chan_a_rx_static      = bank_q[`TCL_BANK_CHAN_A_RX];
  assign chan_a_tx_static      = bank_q[`TCL_BANK_CHAN_A_TX];
  assign chan_a_dynamic        = bank_q[`TCL_BANK_CHAN_A_DYN];
  assign chan_b_rx_static      = bank_q[`TCL_BANK_CHAN_B_RX];
  assign chan_b_tx_static      = bank_q[`TCL_BANK_CHAN_B_TX];
  assign chan_b_dynamic        = bank_q[`TCL_BANK_CHAN_B_DYN];
  assign chan_c_rx_static      = bank_q[`TCL_BANK_CHAN_C_RX];
  assign chan_c_tx_static      = bank_q[`TCL_BANK_CHAN_C_TX];
  assign chan_c_dynamic        = bank_q[`TCL_BANK_CHAN_C_DYN];
  assign chan_d_rx_static      = bank_q[`TCL_BANK_CHAN_D_RX];
  assign chan_d_tx_static      = bank_q[`TCL_BANK_CHAN_D_TX];
  assign chan_d_dynamic        = bank_q[`TCL_BANK_CHAN_D_DYN];
  assign global_rx_static      = bank_q[`TCL_BANK_GLOBAL_RX];
  assign global_tx_static      = bank_q[`TCL_BANK_GLOBAL_TX];
  assign global_dynamic        = bank_q[`TCL_BANK_GLOBAL_DYN];
  assign write_mask_vector     = bank_q[`TCL_BANK_MASK];
  assign channel_global_accept = gaccept;

endmodule // tcl_top

//--- tcl_checker.sv
// concurrent checks on the ports of the configuration latch banks
`timescale 1ns/100ps

module tcl_checker (
  // clock, reset and configuration pins
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [3:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic       config_write_strobe,
  input wire logic [2:0] forced_global_accept,
  // bank contents
  input wire logic [7:0] chan_a_rx_static, chan_a_tx_static, chan_a_dynamic,
  input wire logic [7:0] chan_b_rx_static, chan_b_tx_static, chan_b_dynamic,
  input wire logic [7:0] chan_c_rx_static, chan_c_tx_static, chan_c_dynamic,
  input wire logic [7:0] chan_d_rx_static, chan_d_tx_static, chan_d_dynamic,
  input wire logic [7:0] global_rx_static, global_tx_static, global_dynamic,
  input wire logic [7:0] write_mask_vector,
  input wire logic [3:0] channel_global_accept
);
  // ----------------------------------------------------------------------
  // pin history
  // ----------------------------------------------------------------------
  logic [3:0]      stb_ff;
  logic [3:0][3:0] adr_ff;
  logic [3:0][7:0] dat_ff;
  logic [3:0][2:0] fga_ff;
  logic            hit;
  logic [127:0]    all_q;

  // strobe history is reset so a write never appears to straddle a reset
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stb_ff <= 4'h0;
    end else begin
      stb_ff <= {stb_ff[2:0], config_write_strobe};
    end
  end

  // address, data and forced enables are only read when qualified
  always_ff @(posedge mclk) begin
    adr_ff <= {adr_ff[2:0], cfg_addr};
    dat_ff <= {dat_ff[2:0], cfg_data};
    fga_ff <= {fga_ff[2:0], forced_global_accept};
  end

  // a write lands on this edge: strobe seen twice, pins steady meanwhile
  assign hit = stb_ff[3] & stb_ff[2] & (adr_ff[3] == adr_ff[2]) & (dat_ff[3] == dat_ff[2]);
  assign all_q = {write_mask_vector, global_dynamic, global_tx_static, global_rx_static,
                  chan_d_dynamic, chan_d_tx_static, chan_d_rx_static, chan_c_dynamic,
                  chan_c_tx_static, chan_c_rx_static, chan_b_dynamic, chan_b_tx_static,
                  chan_b_rx_static, chan_a_dynamic, chan_a_tx_static, chan_a_rx_static};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  rst_values_a: assert property ($rose(nrst) |-> write_mask_vector == 8'hff &&
    channel_global_accept == 4'hf) else $error("reset values wrong");
  accept_map_a: assert property (channel_global_accept == {chan_d_dynamic[7],
    chan_c_dynamic[7], chan_b_dynamic[7], chan_a_dynamic[7]}) else $error("accept bits wrong");
  idle_hold_a: assert property (!stb_ff[3] && !stb_ff[2] |=> $stable(all_q))
    else $error("bank changed without strobe");
  mask_load_a: assert property (hit && adr_ff[3] == 4'hf |=>
    write_mask_vector == $past(dat_ff[3])) else $error("mask bank load wrong");
  masked_bank_a: assert property (hit && adr_ff[3] == 4'h1 |=>
    $stable(chan_b_tx_static) &&
    chan_a_tx_static == (($past(chan_a_tx_static) & ~$past(write_mask_vector))
    | ($past(dat_ff[3]) & $past(write_mask_vector)))) else $error("masked write wrong");
  global_fanout_a: assert property (hit && adr_ff[3] == 4'hc &&
    channel_global_accept == 4'hf && write_mask_vector == 8'hff |=>
    {chan_a_rx_static, chan_b_rx_static, chan_c_rx_static, chan_d_rx_static}
    == {4{global_rx_static}}) else $error("global fan-out wrong");
  global_refuse_a: assert property (hit && adr_ff[3] == 4'he &&
    !channel_global_accept[0] && !(fga_ff[3][2] | fga_ff[2][2] | fga_ff[1][2]) |=>
    $stable(chan_a_dynamic)) else $error("refused global write landed");
  forced_on_a: assert property (hit && adr_ff[3] == 4'he &&
    write_mask_vector == 8'hff && (fga_ff[3][2] & fga_ff[2][2] & fga_ff[1][2]) |=>
    chan_a_dynamic == global_dynamic) else $error("forced global write missed");
endmodule // tcl_checker

bind tcl_top tcl_checker chk (.*);

//--- tcl_host_model.sv
// host-side driver of the configuration pins
`timescale 1ns/100ps

module tcl_host_model (
  // clock
  input  wire logic       mclk,
  // configuration pins
  output logic      [3:0] cfg_addr,
  output logic      [7:0] cfg_data,
  output logic            config_write_strobe,
  output logic      [2:0] forced_global_accept
);
  // ----------------------------------------------------------------------
  // pin driving
  // ----------------------------------------------------------------------
  // pins idle low from time zero so nothing is captured during reset
  initial begin
    cfg_addr = 4'h0;
    cfg_data = 8'h00;
    config_write_strobe = 1'b0;
    forced_global_accept = 3'h0;
  end

  // one write, strobe high for n cycles; fewer than two is filtered out
  task automatic write(input logic [3:0] a, input logic [7:0] d, input int n);
    @(posedge mclk);
    cfg_addr <= a;
    cfg_data <= d;
    repeat (4) @(posedge mclk);
    config_write_strobe <= 1'b1;
    repeat (n) @(posedge mclk);
    config_write_strobe <= 1'b0;
    repeat (6) @(posedge mclk);
    cfg_addr <= ~a; // hold time over: pins no longer show the last value
    cfg_data <= ~d;
    @(negedge mclk);
  endtask

  // forced enables change well clear of any write
  task automatic set_forced(input logic [2:0] v);
    @(posedge mclk);
    forced_global_accept <= v;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
  endtask
endmodule // tcl_host_model

//--- tb_tcl_top.sv
// self-checking bench for the configuration latch banks
`timescale 1ns/100ps

module tb_tcl_top;
  logic         mclk = 1'b0;
  logic         nrst = 1'b0;
  logic [3:0]   cfg_addr;
  logic [7:0]   cfg_data;
  logic         config_write_strobe;
  logic [2:0]   forced_global_accept;
  logic [7:0]   chan_a_rx_static, chan_a_tx_static, chan_a_dynamic;
  logic [7:0]   chan_b_rx_static, chan_b_tx_static, chan_b_dynamic;
  logic [7:0]   chan_c_rx_static, chan_c_tx_static, chan_c_dynamic;
  logic [7:0]   chan_d_rx_static, chan_d_tx_static, chan_d_dynamic;
  logic [7:0]   global_rx_static, global_tx_static, global_dynamic;
  logic [7:0]   write_mask_vector;
  logic [3:0]   channel_global_accept;
  logic [127:0] all_q;
  logic [7:0]   exp_q [16];
  int           n_mismatch = 0;
  int           check_count = 0;

  always #5 mclk = ~mclk;

  tcl_top dut (.*);
  tcl_host_model host (.*);

  assign all_q = {write_mask_vector, global_dynamic, global_tx_static, global_rx_static,
                  chan_d_dynamic, chan_d_tx_static, chan_d_rx_static, chan_c_dynamic,
                  chan_c_tx_static, chan_c_rx_static, chan_b_dynamic, chan_b_tx_static,
                  chan_b_rx_static, chan_a_dynamic, chan_a_tx_static, chan_a_rx_static};

  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every bank against the expected image, then the accept bits
  task automatic chk_all(input string what);
    logic [7:0] acc_exp;
    acc_exp = {4'h0, exp_q[11][7], exp_q[8][7], exp_q[5][7], exp_q[2][7]};
    for (int i = 0; i < 16; i++) begin
      chk_byte($sformatf("%s bank %0d", what, i), exp_q[i], all_q[i*8 +: 8]);
    end
    chk_byte("accept", acc_exp, {4'h0, channel_global_accept});
  endtask

  // write through the host and update the expected image; accept bits are read before the write
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input int n = 3);
    logic [7:0] m;
    logic [3:0] acc;
    m = exp_q[15];
    acc = {exp_q[11][7], exp_q[8][7], exp_q[5][7], exp_q[2][7]};
    host.write(a, d, n);
    if (n < 2) return;
    if (a == 4'hf) exp_q[15] = d;
    else exp_q[a] = (exp_q[a] & ~m) | (d & m);
    if (a >= 4'hc && a != 4'hf) begin
      for (int c = 0; c < 4; c++) begin
        if (acc[c] || forced_global_accept[a - 12]) begin
          exp_q[3*c + a - 12] = (exp_q[3*c + a - 12] & ~m) | (d & m);
        end
      end
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 16; i++) begin
      exp_q[i] = (i == 15) ? 8'hff : (i % 3 == 2 && i < 12) ? 8'h80 : 8'h00;
    end
    chk_all("reset");
    $display("test reset done");
  endtask

  // bit 7 kept high in every value so no channel drops out of global writes
  task automatic t_decode();
    for (int i = 0; i < 12; i++) wr(i[3:0], 8'h90 + i[7:0]);
    wr(4'h0, 8'h00, 1); // a one-cycle strobe glitch must be ignored
    chk_all("decode");
    $display("test decode done");
  endtask

  // pulse one bit of channel A's transmit bank, then widen the mask again
  task automatic t_mask();
    wr(4'hf, 8'h02);
    wr(4'h1, 8'hff);
    chk_all("mask set");
    wr(4'h1, 8'h00);
    wr(4'hf, 8'hff);
    chk_all("mask clear");
    $display("test mask done");
  endtask

  // broadcast, refusal on a channel that stopped accepting, then each forced enable
  task automatic t_global();
    wr(4'hc, 8'h3c);
    wr(4'hd, 8'hc3);
    chk_all("global");
    wr(4'h2, 8'h00);
    wr(4'he, 8'h81);
    wr(4'hc, 8'h55);
    chk_all("refuse");
    host.set_forced(3'b101);
    wr(4'he, 8'h05);
    wr(4'hc, 8'h66);
    host.set_forced(3'b010);
    wr(4'hd, 8'h77);
    wr(4'hc, 8'h11);
    chk_all("forced");
    $display("test global done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // a second reset in mid-run must bring back the same values
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    t_reset();
    t_decode();
    t_mask();
    t_global();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
    @(negedge mclk);
    t_reset();
    results();
  end

  // cut a hang short
  initial begin
    #100000;
    n_mismatch++;
    $display("Error watchdog expected end seen hang");
    results();
  end
endmodule // tb_tcl_top
